// *** core/rvc_regs.svh ***
// register offsets, field positions, reset values and timing counts for the regulator control
`ifndef RVC_REGS_SVH
`define RVC_REGS_SVH

`define RVC_NSUP            14
`define RVC_VW              6
`define RVC_NBUCK           4
`define RVC_BUCK0           4'hA
`define RVC_PROC_IDX        4'hB
// register byte offsets
`define RVC_OFS_CTRL        8'h00
`define RVC_OFS_ENABLE      8'h04
`define RVC_OFS_GO          8'h08
`define RVC_OFS_STEP0       8'h0C
`define RVC_OFS_PDOFF       8'h10
`define RVC_OFS_BUCKCFG     8'h14
`define RVC_OFS_SLOT_A      8'h18
`define RVC_OFS_SLOT_B      8'h1C
`define RVC_OFS_STATUS      8'h20
`define RVC_OFS_VSEL_BASE   8'h40
`define RVC_OFS_VSEL_LAST   8'h74
// field positions
`define RVC_CTRL_VLOCK      0
`define RVC_CTRL_COMBINE    1
`define RVC_CTRL_BKDIS      2
`define RVC_CTRL_RDYSEL     3
`define RVC_DEFER_LSB       16
`define RVC_CUR_LSB         8
// supply masks and hardware enable indices
`define RVC_DVC_MASK        14'h1C06
`define RVC_PD_MASK         14'h1C13
`define RVC_HW_IDX0         4'h3
`define RVC_HW_IDX1         4'h4
`define RVC_HW_IDX2         4'h8
// reset values and buck floor code
`define RVC_MODE_RST        8'h55
`define RVC_ILIM_RST        8'hAA
`define RVC_SLOT_RST        56'h00710000032840
`define RVC_FLOOR_CODE      6'h09
// current limits in mA
`define RVC_ILIM0_MA        12'h2BC
`define RVC_ILIM1_MA        12'h320
`define RVC_ILIM2_MA        12'h3E8
`define RVC_ILIM3_MA        12'h4B0
// timing
`define RVC_CLK_MHZ         10
`define RVC_CODE_MV         25
`define RVC_RAMP_UV_PER_US  6250
`define RVC_RAMP_CYC        ((`RVC_CODE_MV * 1000 * `RVC_CLK_MHZ) / `RVC_RAMP_UV_PER_US)
`define RVC_SOFTSTART_US    200
`define RVC_SOFTSTART_CYC   (`RVC_SOFTSTART_US * `RVC_CLK_MHZ)

`endif

// *** core/rvc_pkg.sv ***
// types shared by the regulator voltage control
`include "rvc_regs.svh"
package rvc_pkg;

  typedef enum logic [1:0] {
    RVC_MODE_SLEEP,
    RVC_MODE_AUTO,
    RVC_MODE_SYNC,
    RVC_MODE_AUTO_SYNC
  } rvc_mode_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } rvc_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } rvc_avs_rsp_t;

  typedef struct packed {
    logic       strobe;
    logic       up;
    logic [3:0] slot;
    logic       system_reload;
    logic       reset_mode;
  } rvc_seq_t;

  typedef struct packed {
    logic [`RVC_NSUP-1:0]                 en;
    logic [`RVC_NSUP-1:0]                 defer;
    logic [`RVC_NSUP-1:0]                 pend_en;
    logic [`RVC_NSUP-1:0]                 go;
    logic [`RVC_NSUP-1:0]                 step0;
    logic [`RVC_NSUP-1:0]                 pd_off;
    logic [`RVC_NSUP-1:0][`RVC_VW-1:0]    tgt;
    logic [`RVC_NSUP-1:0][`RVC_VW-1:0]    app;
    logic [`RVC_NSUP-1:0][`RVC_VW-1:0]    cur;
    logic [`RVC_NSUP-1:0][3:0]            slot;
    logic                                 vlock;
    logic                                 combine;
    logic                                 bkdis;
    logic                                 rdysel;
    logic [`RVC_NBUCK-1:0][1:0]           mode;
    logic [`RVC_NBUCK-1:0][1:0]           ilim;
    logic [`RVC_NBUCK-1:0][11:0]          ilim_ma;
    logic [2:0]                           sleepf;
    logic [1:0][3:0]                      sw_slot;
    logic [1:0]                           sw_on;
    logic [1:0][10:0]                     sw_cnt;
    logic [5:0]                           tick;
    logic                                 loaded;
    logic [2:0]                           late_v;
    logic [2:0]                           late_val;
    logic [2:0]                           evclr;
    logic [2:0]                           sy1;
    logic [2:0]                           sy2;
    logic                                 ack;
    logic [31:0]                          rdata;
  } rvc_state_t;

endpackage

// *** core/rvc_ctrl.sv ***
// regulator and buck voltage, enable and mode control with register slave
`timescale 1ns/10ps
`default_nettype none
`include "rvc_regs.svh"
module rvc_ctrl (
  input  wire logic                                 clk,
  input  wire logic                                 sys_rst,
  input  wire rvc_pkg::rvc_avs_req_t                avs_req,
  output rvc_pkg::rvc_avs_rsp_t                     avs_rsp,
  input  wire rvc_pkg::rvc_seq_t                    seq,
  input  wire logic                                 pm_active,
  input  wire logic [`RVC_NSUP-1:0][`RVC_VW-1:0]    otp_vsel,
  input  wire logic [2:0]                           gpi_level,
  input  wire logic [2:0]                           gpi_event,
  input  wire logic [2:0]                           gpi_debounce_off,
  output logic [2:0]                                gpi_event_clr,
  output logic [`RVC_NSUP-1:0]                      supply_en,
  output logic [`RVC_NSUP-1:0][`RVC_VW-1:0]         supply_vsel,
  output logic [`RVC_NSUP-1:0]                      supply_pulldown,
  output rvc_pkg::rvc_mode_t [`RVC_NBUCK-1:0]       buck_mode,
  output logic [`RVC_NBUCK-1:0][11:0]               buck_ilim_ma,
  output logic [1:0]                                sw_closed,
  output logic [1:0]                                sw_softstart,
  output logic [1:0]                                sw_pulldown,
  output logic                                      feedback_ready,
  output logic                                      ref_backup_switch_disable
);
  import rvc_pkg::*;

  localparam int RAMP_CYC = `RVC_RAMP_CYC;
  localparam int SS_CYC   = `RVC_SOFTSTART_CYC;
  localparam logic [5:0]  RAMP_LAST = 6'(RAMP_CYC - 1);
  localparam logic [10:0] SS_LAST   = 11'(SS_CYC);
  localparam logic [`RVC_NSUP-1:0] DVC_MASK = `RVC_DVC_MASK;
  localparam logic [3:0]  HW_IDX [3] = '{`RVC_HW_IDX0, `RVC_HW_IDX1, `RVC_HW_IDX2};

  rvc_state_t s;
  rvc_state_t next_s;
  logic       wr;
  logic       rd;
  logic       ramping;
  logic [31:0] wv;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_vsel(input logic [7:0] a);
    return a >= `RVC_OFS_VSEL_BASE && a <= `RVC_OFS_VSEL_LAST && a[1:0] == 2'h0;
  endfunction

  function automatic logic [11:0] ilim_ma_f(input logic [1:0] c);
    unique case (c)
      2'h0: return `RVC_ILIM0_MA;
      2'h1: return `RVC_ILIM1_MA;
      2'h2: return `RVC_ILIM2_MA;
      2'h3: return `RVC_ILIM3_MA;
    endcase
  endfunction

  function automatic logic [31:0] rd_word(input rvc_state_t st, input logic [7:0] a);
    logic [3:0]  vi;
    logic [31:0] w;
    vi = 4'(a[7:2] - 6'h10);
    w  = 32'h00000000;
    if (is_vsel(a)) begin
      w[`RVC_VW-1:0] = st.tgt[vi];
      w[`RVC_CUR_LSB +: `RVC_VW] = st.cur[vi];
    end else begin
      unique case (a)
        `RVC_OFS_CTRL:    w[3:0] = {st.rdysel, st.bkdis, st.combine, st.vlock};
        `RVC_OFS_ENABLE:  w = {2'h0, st.defer, 2'h0, st.en};
        `RVC_OFS_GO:      w[`RVC_NSUP-1:0] = st.go;
        `RVC_OFS_STEP0:   w[`RVC_NSUP-1:0] = st.step0;
        `RVC_OFS_PDOFF:   w[`RVC_NSUP-1:0] = st.pd_off;
        `RVC_OFS_BUCKCFG: w[15:0] = {st.ilim, st.mode};
        `RVC_OFS_SLOT_A:  w = st.slot[7:0];
        `RVC_OFS_SLOT_B:  w = {st.sw_slot, st.slot[13:8]};
        `RVC_OFS_STATUS:  w[7:0] = {(st.sw_on & ~{st.sw_cnt[1] == SS_LAST,
                                   st.sw_cnt[0] == SS_LAST}), st.sw_on, st.sleepf,
                                   st.cur != st.app};
        default:          w = 32'h00000000;
      endcase
    end
    return w;
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] d,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // bus slave: one wait state, read data latched at the edge that raises ack, write applied at the edge while ack is high
  // ----------------------------------------------------------------
  assign wr = avs_req.write & s.ack;
  assign rd = avs_req.read & ~s.ack;
  assign wv = be_merge(rd_word(s, avs_req.address), avs_req.writedata, avs_req.byteenable);
  assign avs_rsp.waitrequest = (avs_req.read | avs_req.write) & ~s.ack;
  assign avs_rsp.readdata    = s.rdata;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0]            vi;
    logic [`RVC_NSUP-1:0]  touched;
    logic                  may_v;
    vi      = 4'(avs_req.address[7:2] - 6'h10);
    touched = '0;
    may_v   = pm_active & ~s.vlock;
    next_s       = s;
    next_s.ack   = (avs_req.read | avs_req.write) & ~s.ack;
    next_s.rdata = rd ? rd_word(s, avs_req.address) : s.rdata;
    next_s.evclr = 3'h0;
    next_s.sy1   = gpi_level;
    next_s.sy2   = s.sy1;
    next_s.tick  = (s.tick == RAMP_LAST) ? 6'h00 : 6'(s.tick + 6'h01);
    if (!s.loaded) begin
      next_s.loaded = 1'b1;
      next_s.tgt    = otp_vsel;
      next_s.app    = otp_vsel;
      next_s.cur    = otp_vsel;
    end
    if (wr && pm_active) begin
      if (is_vsel(avs_req.address)) begin
        if (may_v && !s.go[vi] && !(s.combine && vi == `RVC_PROC_IDX)) begin
          next_s.tgt[vi] = wv[`RVC_VW-1:0];
          if (!DVC_MASK[vi] && !s.defer[vi]) begin
            next_s.app[vi] = wv[`RVC_VW-1:0];
          end
        end
      end else begin
        unique case (avs_req.address)
          `RVC_OFS_CTRL: begin
            next_s.vlock   = wv[`RVC_CTRL_VLOCK];
            next_s.combine = wv[`RVC_CTRL_COMBINE];
            next_s.bkdis   = wv[`RVC_CTRL_BKDIS];
            next_s.rdysel  = wv[`RVC_CTRL_RDYSEL];
          end
          `RVC_OFS_ENABLE: begin
            for (int i = 0; i < `RVC_NSUP; i++) begin
              next_s.defer[i] = wv[`RVC_DEFER_LSB + i];
              if (wv[`RVC_DEFER_LSB + i]) begin
                next_s.pend_en[i] = wv[i];
              end else begin
                next_s.en[i] = wv[i];
                touched[i]   = 1'b1;
              end
            end
          end
          `RVC_OFS_GO: begin
            for (int i = 0; i < `RVC_NSUP; i++) begin
              if (may_v && wv[i] && DVC_MASK[i] && !s.defer[i]
                  && !(s.combine && i == `RVC_PROC_IDX)) begin
                next_s.go[i]  = 1'b1;
                next_s.app[i] = s.tgt[i];
              end
            end
          end
          `RVC_OFS_STEP0: next_s.step0  = wv[`RVC_NSUP-1:0];
          `RVC_OFS_PDOFF: next_s.pd_off = wv[`RVC_NSUP-1:0] & `RVC_PD_MASK;
          `RVC_OFS_BUCKCFG: begin
            for (int b = 0; b < `RVC_NBUCK; b++) begin
              if (!(s.combine && b == 1)) begin
                next_s.mode[b] = wv[2*b +: 2];
                next_s.ilim[b] = wv[8 + 2*b +: 2];
              end
            end
          end
          `RVC_OFS_SLOT_A: next_s.slot[7:0] = wv;
          `RVC_OFS_SLOT_B: begin
            next_s.slot[13:8] = wv[23:0];
            next_s.sw_slot    = wv[31:24];
          end
          default: begin
          end
        endcase
      end
    end
    // sequencer slots
    if (seq.strobe) begin
      for (int i = 0; i < `RVC_NSUP; i++) begin
        if (seq.slot == 4'h0) begin
          if (seq.up && s.step0[i]) begin
            next_s.en[i]  = 1'b1;
            next_s.tgt[i] = otp_vsel[i];
            next_s.app[i] = otp_vsel[i];
            touched[i]    = 1'b1;
          end
        end else if (s.slot[i] == seq.slot) begin
          touched[i] = 1'b1;
          if (seq.up) begin
            next_s.en[i] = 1'b1;
          end else if (s.defer[i]) begin
            next_s.en[i]  = s.pend_en[i];
            next_s.app[i] = s.tgt[i];
          end else begin
            next_s.en[i] = 1'b0;
          end
        end
      end
      for (int k = 0; k < 2; k++) begin
        if (seq.slot != 4'h0 && s.sw_slot[k] == seq.slot) begin
          next_s.sw_on[k] = seq.up;
        end
      end
    end
    if (seq.system_reload) begin
      next_s.tgt   = otp_vsel;
      next_s.app   = otp_vsel;
      next_s.defer = '0;
    end
    // hardware enables through undebounced GPI events
    for (int k = 0; k < 3; k++) begin
      if (s.late_v[k]) begin
        next_s.en[HW_IDX[k]] = s.late_val[k];
        next_s.late_v[k]     = 1'b0;
      end
      if (gpi_event[k] && gpi_debounce_off[k]) begin
        next_s.evclr[k] = 1'b1;
        if (touched[HW_IDX[k]]) begin
          next_s.late_v[k]   = 1'b1;
          next_s.late_val[k] = next_s.en[HW_IDX[k]];
        end
        next_s.en[HW_IDX[k]] = s.sy2[k];
      end
    end
    if (seq.reset_mode) begin
      next_s.en[`RVC_NSUP-1:1] = '0;
      next_s.late_v            = 3'h0;
    end
    // buck floor and forced sleep
    for (int b = 0; b < 3; b++) begin
      if (next_s.app[`RVC_BUCK0 + b] < `RVC_FLOOR_CODE) begin
        next_s.app[`RVC_BUCK0 + b] = `RVC_FLOOR_CODE;
      end
      next_s.sleepf[b] = next_s.tgt[`RVC_BUCK0 + b] < `RVC_FLOOR_CODE;
    end
    // ramp one code per tick toward the applied value
    for (int i = 0; i < `RVC_NSUP; i++) begin
      if (s.go[i] && s.cur[i] == s.app[i]) begin
        next_s.go[i] = 1'b0;
      end
      if (s.loaded && s.tick == 6'h00) begin
        if (s.cur[i] < s.app[i]) begin
          next_s.cur[i] = 6'(s.cur[i] + 6'h01);
        end else if (s.cur[i] > s.app[i]) begin
          next_s.cur[i] = 6'(s.cur[i] - 6'h01);
        end
      end
    end
    for (int k = 0; k < 2; k++) begin
      if (!next_s.sw_on[k]) begin
        next_s.sw_cnt[k] = 11'h000;
      end else if (s.sw_cnt[k] != SS_LAST) begin
        next_s.sw_cnt[k] = 11'(s.sw_cnt[k] + 11'h001);
      end
    end
    for (int b = 0; b < `RVC_NBUCK; b++) begin
      next_s.ilim_ma[b] = ilim_ma_f(next_s.ilim[b]);
    end
    if (next_s.combine) begin
      next_s.ilim_ma[0] = 12'(ilim_ma_f(next_s.ilim[0]) << 1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s         <= '0;
      s.slot    <= `RVC_SLOT_RST;
      s.mode    <= `RVC_MODE_RST;
      s.ilim    <= `RVC_ILIM_RST;
      s.ilim_ma <= {`RVC_ILIM2_MA, `RVC_ILIM2_MA, `RVC_ILIM2_MA, `RVC_ILIM2_MA};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign ramping                   = s.cur != s.app;
  assign feedback_ready            = s.rdysel & ramping;
  assign gpi_event_clr             = s.evclr;
  assign supply_en                 = s.en;
  assign supply_vsel               = s.cur;
  assign supply_pulldown           = ~s.en & ~s.pd_off;
  assign buck_ilim_ma              = s.ilim_ma;
  assign ref_backup_switch_disable = s.bkdis;
  assign sw_closed                 = s.sw_on;
  assign sw_pulldown               = ~s.sw_on;
  generate
    for (genvar b = 0; b < `RVC_NBUCK; b++) begin : g_mode
      if (b < 3) begin : g_dvc
        assign buck_mode[b] = s.sleepf[b] ? RVC_MODE_SLEEP : rvc_mode_t'(s.mode[b]);
      end else begin : g_fix
        assign buck_mode[b] = rvc_mode_t'(s.mode[b]);
      end
    end
    for (genvar k = 0; k < 2; k++) begin : g_sw
      assign sw_softstart[k] = s.sw_on[k] & (s.sw_cnt[k] != SS_LAST);
    end
  endgenerate

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_lock_vsel;
    wr && s.vlock && is_vsel(avs_req.address) && !seq.system_reload && !seq.strobe
      |=> s.tgt == $past(s.tgt);
  endproperty
  a_lock_vsel: assert property (p_lock_vsel) else $error("voltage written under lock");

  property p_startup;
    !s.loaded |=> s.tgt == $past(otp_vsel) && s.cur == $past(otp_vsel);
  endproperty
  a_startup: assert property (p_startup) else $error("otp defaults not loaded");

  property p_reload;
    seq.system_reload |=> s.defer == '0 && s.tgt == $past(otp_vsel);
  endproperty
  a_reload: assert property (p_reload) else $error("deferred bits not cleared");

  property p_reset_mode;
    seq.reset_mode |=> s.en[`RVC_NSUP-1:1] == '0;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("supply left on in reset");

  property p_ramp_rate;
    $changed(s.cur) |-> $past(s.tick) == 6'h00 || !$past(s.loaded);
  endproperty
  a_ramp_rate: assert property (p_ramp_rate) else $error("voltage moved off tick");

  property p_go_blocks;
    wr && avs_req.address == `RVC_OFS_VSEL_BASE + 8'h04 && s.go[1] && !seq.system_reload
      && !seq.strobe |=> s.tgt[1] == $past(s.tgt[1]);
  endproperty
  a_go_blocks: assert property (p_go_blocks) else $error("voltage written during slew");

  property p_go_clear;
    s.go[`RVC_BUCK0] && s.cur[`RVC_BUCK0] == s.app[`RVC_BUCK0] && !wr
      |=> !s.go[`RVC_BUCK0];
  endproperty
  a_go_clear: assert property (p_go_clear) else $error("go not cleared at target");

  property p_hw_en;
    gpi_event[0] && gpi_debounce_off[0] && !seq.reset_mode
      |=> s.evclr[0] && s.en[`RVC_HW_IDX0] == $past(s.sy2[0]) ##1 !s.evclr[0];
  endproperty
  a_hw_en: assert property (p_hw_en) else $error("hardware enable not applied");

  property p_floor;
    s.loaded |-> s.app[`RVC_BUCK0] >= `RVC_FLOOR_CODE;
  endproperty
  a_floor: assert property (p_floor) else $error("buck ramp below floor");

  property p_merge;
    s.combine && $past(s.combine) && $stable(s.ilim[0])
      |-> buck_ilim_ma[0] == 12'(ilim_ma_f(s.ilim[0]) << 1);
  endproperty
  a_merge: assert property (p_merge) else $error("merged limit not doubled");

  c_ramp: cover property (feedback_ready ##1 !feedback_ready);
  c_defer: cover property (seq.strobe && !seq.up && |s.defer);
  c_hw_late: cover property (s.late_v != 3'h0);
  c_sw_done: cover property ($fell(sw_softstart[0]) && sw_closed[0]);

endmodule
`default_nettype wire

// *** sim/rvc_host.sv ***
// avalon master standing in for the host processor
`timescale 1ns/10ps
`default_nettype none
module rvc_host (
  input  wire logic                  clk,
  output rvc_pkg::rvc_avs_req_t      avs_req,
  input  wire rvc_pkg::rvc_avs_rsp_t avs_rsp
);
  import rvc_pkg::*;
  initial avs_req = '0;
  // one access: hold until waitrequest is seen low, then an idle edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    avs_req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hF};
    @(posedge clk iff avs_rsp.waitrequest === 1'b0);
    q = avs_rsp.readdata;
    avs_req <= '0;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** sim/test_regulator_voltage_control.sv ***
// self-checking bench for the regulator voltage control
`timescale 1ns/10ps
`default_nettype none
`include "rvc_regs.svh"
module test_regulator_voltage_control;
  import rvc_pkg::*;
  logic                              clk = 0;
  logic                              sys_rst = 1;
  rvc_avs_req_t                      req;
  rvc_avs_rsp_t                      rsp;
  rvc_seq_t                          seq = '0;
  logic [`RVC_NSUP-1:0][`RVC_VW-1:0] otp;
  logic [`RVC_NSUP-1:0][`RVC_VW-1:0] vsel;
  logic [`RVC_NSUP-1:0]              en;
  rvc_mode_t [`RVC_NBUCK-1:0]        bm;
  logic [`RVC_NBUCK-1:0][11:0]       ilim;
  logic [2:0]                        lvl = 0, ev = 0, dbo = 0, evclr;
  logic                              rdy, clr_seen = 0;
  logic [31:0]                       q;
  int                                n_fail = 0, tests_run = 0, cyc = 0;

  rvc_host i_rvc_host (.clk(clk), .avs_req(req), .avs_rsp(rsp));
  rvc_ctrl i_rvc_ctrl (.clk(clk), .sys_rst(sys_rst), .avs_req(req), .avs_rsp(rsp),
    .seq(seq), .pm_active(1'b1), .otp_vsel(otp), .gpi_level(lvl), .gpi_event(ev),
    .gpi_debounce_off(dbo), .gpi_event_clr(evclr), .supply_en(en), .supply_vsel(vsel),
    .supply_pulldown(), .buck_mode(bm), .buck_ilim_ma(ilim), .sw_closed(),
    .sw_softstart(), .sw_pulldown(), .feedback_ready(rdy), .ref_backup_switch_disable());

  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (evclr[0] === 1'b1) clr_seen <= 1'b1;
    if (cyc == 5000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t seen %0h expected %0h", $time, s, e);
    end
  endtask

  task automatic print_verdict;
    if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    for (int i = 0; i < `RVC_NSUP; i++) otp[i] = 6'(i + 20);
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(vsel[5], 25);
    chk(bm[0], RVC_MODE_AUTO);
    i_rvc_host.bus(0, 8'h30, 0, q);
    chk(q, 0);
    i_rvc_host.bus(1, `RVC_OFS_CTRL, 32'h9, q);
    i_rvc_host.bus(1, 8'h54, 32'd40, q);
    i_rvc_host.bus(0, 8'h54, 0, q);
    chk(q[5:0], 25);
    i_rvc_host.bus(1, `RVC_OFS_CTRL, 32'h8, q);
    i_rvc_host.bus(1, 8'h44, 32'd23, q);
    i_rvc_host.bus(1, `RVC_OFS_GO, 32'h2, q);
    chk(rdy, 1);
    i_rvc_host.bus(1, 8'h44, 32'd30, q);
    i_rvc_host.bus(0, `RVC_OFS_GO, 0, q);
    chk(q[1], 1);
    repeat (120) @(posedge clk);
    i_rvc_host.bus(0, `RVC_OFS_GO, 0, q);
    chk(q[1], 0);
    i_rvc_host.bus(0, 8'h44, 0, q);
    chk(q[13:0], 14'h1717);
    chk(vsel[1], 23);
    i_rvc_host.bus(1, `RVC_OFS_ENABLE, 32'h401, q);
    @(posedge clk);
    chk(en, 14'h0401);
    seq <= '{strobe: 1'b0, up: 1'b0, slot: 4'h0, system_reload: 1'b0, reset_mode: 1'b1};
    @(posedge clk);
    seq <= '0;
    repeat (2) @(posedge clk);
    chk(en, 14'h0001);
    i_rvc_host.bus(1, `RVC_OFS_STEP0, 32'h1000, q);
    seq <= '{strobe: 1'b1, up: 1'b1, slot: 4'h0, system_reload: 1'b0, reset_mode: 1'b0};
    @(posedge clk);
    seq <= '0;
    repeat (2) @(posedge clk);
    chk(en[12], 1);
    seq <= '{strobe: 1'b0, up: 1'b0, slot: 4'h0, system_reload: 1'b1, reset_mode: 1'b0};
    @(posedge clk);
    seq <= '0;
    i_rvc_host.bus(0, 8'h44, 0, q);
    chk(q[5:0], 21);
    dbo <= 3'b001;
    lvl <= 3'b001;
    repeat (3) @(posedge clk);
    // event flag raised for one cycle, interrupt assumed masked by the host
    ev <= 3'b001;
    @(posedge clk);
    ev <= 3'b000;
    repeat (2) @(posedge clk);
    chk(en[3], 1);
    chk(clr_seen, 1);
    i_rvc_host.bus(1, `RVC_OFS_CTRL, 32'h2, q);
    @(posedge clk);
    chk(ilim[0], 12'h7D0);
    print_verdict();
  end
endmodule
`default_nettype wire
